/* core/host_timers_pkg.sv */
// constants shared by the host timer and halfword-order register bank
package host_timers_pkg;
	// register byte offsets
	localparam logic [7:0] GPT_CONFIG_OFS = 8'h8c;
	localparam logic [7:0] GPT_COUNT_OFS = 8'h90;
	localparam logic [7:0] HALF_ORDER_OFS = 8'h98;
	localparam logic [7:0] TICK_COUNT_OFS = 8'h9c;
	localparam logic [7:0] INT_STATUS_OFS = 8'hb0;
	localparam logic [7:0] INT_MASK_OFS = 8'hb4;
	localparam logic [7:0] CONTROL_OFS = 8'hb8;
	// field positions
	localparam int TIMER_RUN_BIT = 29;
	localparam int PRELOAD_MSB = 15;
	localparam int BUS16_BIT = 0;
	localparam int TIMER_INT_BIT = 0;
	localparam int TICK_WRAP_INT_BIT = 1;
	localparam int INT_BITS = 2;
	// reset values, swap order and tick limit
	localparam logic [15:0] PRELOAD_RESET = 16'hffff;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [31:0] HALF_ORDER_RESET = 32'h00000000;
	localparam logic [31:0] HALF_ORDER_SWAP = 32'hffffffff;
	localparam logic [31:0] TICK_RESET = 32'h00000000;
	localparam logic [31:0] TICK_MAX = 32'hffffffff;
	// timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int TICK_CLEAR_NS = 160;
	localparam int TICK_CLEAR_CYCLES = (TICK_CLEAR_NS / CLK_PERIOD_NS) < 1 ? 1
		: TICK_CLEAR_NS / CLK_PERIOD_NS;
endpackage : host_timers_pkg

/* core/halfword_if.sv */
// carries a 16-bit halfword access between the bank and the halfword steering unit
`timescale 1ns/10ps
interface halfword_if;
	logic addr_bit1;
	logic bus16;
	logic [31:0] order;
	logic high_half;
	modport bank (output addr_bit1, output bus16, output order, input high_half);
	modport steer (input addr_bit1, input bus16, input order, output high_half);
endinterface : halfword_if

/* core/halfword_steer.sv */
// decides which halfword of a 32-bit register a 16-bit host access reaches
`timescale 1ns/10ps
module halfword_steer (
	halfword_if.steer hw
);
	// in 16-bit mode all ones reverses the pairing, any other value keeps address bit one as the high half; 32-bit mode always takes the low half
	always_comb begin
		if (!hw.bus16) begin
			hw.high_half = 1'b0; // R8
		end else if (hw.order == host_timers_pkg::HALF_ORDER_SWAP) begin
			hw.high_half = ~hw.addr_bit1; // R11
		end else begin
			hw.high_half = hw.addr_bit1; // R10
		end
	end
endmodule : halfword_steer

/* core/host_timers.sv */
// general purpose timer, free-running tick counter and halfword order over APB
//
// What this block does
// R1 - running timer paces periodic host interrupts
// R2 - writing one to bit 29 starts timer
// R3 - cleared run bit halts the count
// R4 - run falling edge forces preload to ones
// R5 - preload bits 15:0, rw, resets ones
// R6 - count register shows present count, ones after reset
// R7 - decrement, at zero flag and reload
// R8 - halfword order matters in 16-bit mode only
// R9 - 32-bit bus keeps natural halfword lanes
// R10 - other orders: address bit one is high
// R11 - all ones order: address bit one is low
// R12 - transmit path sends low halfword first
// R13 - receive path stores low halfword first
// R14 - tick counter from zero, one per cycle
// R15 - tick counter wraps to zero
// R16 - first 16-bit read latches whole count
// R17 - tick counter clears within 160 ns
// R18 - tick counter runs in every power state
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module host_timers (
	// clock and reset
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	// apb slave
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	// transmit data path, one 32-bit fifo word split into two halfwords
	input wire logic TX_WORD_VALID_IN,
	input wire logic [31:0] TX_WORD_IN,
	output logic TX_WORD_READY_OUT,
	output logic TX_HALF_VALID_OUT,
	output logic [15:0] TX_HALF_OUT,
	// receive data path, two halfwords packed into one fifo word
	input wire logic RX_HALF_VALID_IN,
	input wire logic [15:0] RX_HALF_IN,
	output logic RX_WORD_VALID_OUT,
	output logic [31:0] RX_WORD_OUT,
	// interrupt
	output logic IRQ_OUT
);
	typedef struct packed {
		logic timer_run;
		logic [15:0] preload;
		logic [15:0] count;
		logic [31:0] half_order;
		logic [31:0] tick;
		logic [31:0] tick_latch;
		logic tick_latched;
		logic [2:0] clear_cnt;
		logic bus16;
		logic [1:0] int_status;
		logic [1:0] int_mask;
		logic [31:0] rdata;
		logic tx_busy;
		logic tx_second;
		logic [15:0] tx_high;
		logic [15:0] tx_half;
		logic tx_half_valid;
		logic rx_have_low;
		logic [15:0] rx_low;
		logic [31:0] rx_word;
		logic rx_word_valid;
	} state_s;

	state_s cur_reg;
	state_s nxt_next;

	halfword_if hw ();

	halfword_steer u_steer (
		.hw(hw.steer)
	);

	logic setup;
	logic access;
	logic wr;
	logic rd;
	logic mapped;
	logic [31:0] wdata32;
	logic [31:0] rd_word;
	logic [15:0] rd_half;
	logic [31:0] tick_view;

	assign setup = PSEL_IN & ~PENABLE_IN;
	assign access = PSEL_IN & PENABLE_IN;
	// zero-wait slave: every access phase completes in its first cycle
	assign wr = access & PWRITE_IN;
	// read side effects go with the data capture in the setup cycle, so no event slips between
	assign rd = setup & ~PWRITE_IN;
	assign mapped = PADDR_IN[7:2] == host_timers_pkg::GPT_CONFIG_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::GPT_COUNT_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::HALF_ORDER_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::TICK_COUNT_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::INT_STATUS_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::INT_MASK_OFS[7:2]
		|| PADDR_IN[7:2] == host_timers_pkg::CONTROL_OFS[7:2];

	assign hw.addr_bit1 = PADDR_IN[1];
	assign hw.bus16 = cur_reg.bus16;
	assign hw.order = cur_reg.half_order;

	// the tick counter reads as zero until the post-reset clear window has passed
	assign tick_view = (cur_reg.clear_cnt != 3'h0) ? host_timers_pkg::TICK_RESET
		: cur_reg.tick; // R17

	// full register value at the addressed word
	always_comb begin
		rd_word = 32'h00000000;
		case (PADDR_IN[7:2])
			host_timers_pkg::GPT_CONFIG_OFS[7:2]: begin
				rd_word[host_timers_pkg::TIMER_RUN_BIT] = cur_reg.timer_run;
				rd_word[host_timers_pkg::PRELOAD_MSB:0] = cur_reg.preload;
			end
			host_timers_pkg::GPT_COUNT_OFS[7:2]: begin
				rd_word[15:0] = cur_reg.count; // R6
			end
			host_timers_pkg::HALF_ORDER_OFS[7:2]: begin
				rd_word = cur_reg.half_order;
			end
			host_timers_pkg::TICK_COUNT_OFS[7:2]: begin
				// second halfword of a 16-bit pair returns the held capture
				rd_word = (cur_reg.bus16 && cur_reg.tick_latched) ? cur_reg.tick_latch
					: tick_view; // R16
			end
			host_timers_pkg::INT_STATUS_OFS[7:2]: begin
				rd_word[1:0] = cur_reg.int_status;
			end
			host_timers_pkg::INT_MASK_OFS[7:2]: begin
				rd_word[1:0] = cur_reg.int_mask;
			end
			host_timers_pkg::CONTROL_OFS[7:2]: begin
				rd_word[host_timers_pkg::BUS16_BIT] = cur_reg.bus16;
			end
			default: begin
				rd_word = 32'h00000000;
			end
		endcase
	end

	assign rd_half = hw.high_half ? rd_word[31:16] : rd_word[15:0];

	// write data seen as a full word; a 16-bit write touches only the steered half
	always_comb begin
		if (cur_reg.bus16) begin // R8
			wdata32 = hw.high_half ? {PWDATA_IN[15:0], rd_word[15:0]}
				: {rd_word[31:16], PWDATA_IN[15:0]};
		end else begin
			wdata32 = PWDATA_IN; // R9
		end
	end

	always_comb begin
		logic timer_event;
		logic wrap_event;
		logic [1:0] events;
		timer_event = 1'b0;
		wrap_event = 1'b0;
		events = 2'b00;
		nxt_next = cur_reg;

		// tick counter: no power-state input gates it
		nxt_next.tick = cur_reg.tick + 32'h00000001; // R14 R15 R18
		wrap_event = cur_reg.tick == host_timers_pkg::TICK_MAX;
		if (cur_reg.clear_cnt != 3'h0) begin
			nxt_next.clear_cnt = cur_reg.clear_cnt - 3'h1;
		end

		// general purpose timer
		if (cur_reg.timer_run) begin // R3
			if (cur_reg.count == 16'h0000) begin
				nxt_next.count = cur_reg.preload; // R7
				timer_event = 1'b1; // R1
			end else begin
				nxt_next.count = cur_reg.count - 16'h0001; // R7
			end
		end

		// register writes
		if (wr) begin
			case (PADDR_IN[7:2])
				host_timers_pkg::GPT_CONFIG_OFS[7:2]: begin
					nxt_next.timer_run = wdata32[host_timers_pkg::TIMER_RUN_BIT]; // R2
					nxt_next.preload = wdata32[host_timers_pkg::PRELOAD_MSB:0]; // R5
					if (!cur_reg.timer_run && wdata32[host_timers_pkg::TIMER_RUN_BIT]) begin
						nxt_next.count = wdata32[host_timers_pkg::PRELOAD_MSB:0]; // R5
					end
					if (cur_reg.timer_run && !wdata32[host_timers_pkg::TIMER_RUN_BIT]) begin
						nxt_next.preload = host_timers_pkg::PRELOAD_RESET; // R4
					end
				end
				host_timers_pkg::HALF_ORDER_OFS[7:2]: begin
					nxt_next.half_order = wdata32;
				end
				host_timers_pkg::INT_MASK_OFS[7:2]: begin
					nxt_next.int_mask = wdata32[1:0];
				end
				host_timers_pkg::CONTROL_OFS[7:2]: begin
					nxt_next.bus16 = wdata32[host_timers_pkg::BUS16_BIT];
				end
				default: begin
				end
			endcase
		end

		// 16-bit tick reads: first latches, second releases
		if (rd && PADDR_IN[7:2] == host_timers_pkg::TICK_COUNT_OFS[7:2] && cur_reg.bus16) begin
			if (cur_reg.tick_latched) begin
				nxt_next.tick_latched = 1'b0;
			end else begin
				nxt_next.tick_latch = tick_view; // R16
				nxt_next.tick_latched = 1'b1;
			end
		end

		// read data held in a flop, sampled by the master at the access edge
		if (setup) begin
			nxt_next.rdata = cur_reg.bus16 ? {16'h0000, rd_half} : rd_word;
		end

		// sticky status: read clears, a same-cycle event still sets
		events[host_timers_pkg::TIMER_INT_BIT] = timer_event;
		events[host_timers_pkg::TICK_WRAP_INT_BIT] = wrap_event;
		if (rd && PADDR_IN[7:2] == host_timers_pkg::INT_STATUS_OFS[7:2]) begin
			nxt_next.int_status = events;
		end else begin
			nxt_next.int_status = cur_reg.int_status | events;
		end

		// transmit: low halfword leaves first, order setting plays no part
		nxt_next.tx_half_valid = 1'b0;
		if (cur_reg.tx_busy) begin
			nxt_next.tx_half = cur_reg.tx_high;
			nxt_next.tx_half_valid = 1'b1;
			nxt_next.tx_busy = 1'b0;
		end else if (TX_WORD_VALID_IN) begin
			nxt_next.tx_half = TX_WORD_IN[15:0]; // R12
			nxt_next.tx_high = TX_WORD_IN[31:16];
			nxt_next.tx_half_valid = 1'b1;
			nxt_next.tx_busy = 1'b1;
		end

		// receive: first halfword is the low half
		nxt_next.rx_word_valid = 1'b0;
		if (RX_HALF_VALID_IN) begin
			if (cur_reg.rx_have_low) begin
				nxt_next.rx_word = {RX_HALF_IN, cur_reg.rx_low}; // R13
				nxt_next.rx_word_valid = 1'b1;
				nxt_next.rx_have_low = 1'b0;
			end else begin
				nxt_next.rx_low = RX_HALF_IN; // R13
				nxt_next.rx_have_low = 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			cur_reg <= '0;
			cur_reg.preload <= host_timers_pkg::PRELOAD_RESET; // R5
			cur_reg.count <= host_timers_pkg::COUNT_RESET; // R6
			cur_reg.half_order <= host_timers_pkg::HALF_ORDER_RESET; // R8
			cur_reg.tick <= host_timers_pkg::TICK_RESET; // R14
			cur_reg.clear_cnt <= 3'(host_timers_pkg::TICK_CLEAR_CYCLES); // R17
		end else begin
			cur_reg <= nxt_next;
		end
	end

	assign PRDATA_OUT = cur_reg.rdata;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = access & ~mapped;
	assign TX_WORD_READY_OUT = ~cur_reg.tx_busy;
	assign TX_HALF_VALID_OUT = cur_reg.tx_half_valid;
	assign TX_HALF_OUT = cur_reg.tx_half;
	assign RX_WORD_VALID_OUT = cur_reg.rx_word_valid;
	assign RX_WORD_OUT = cur_reg.rx_word;
	assign IRQ_OUT = |(cur_reg.int_status & cur_reg.int_mask); // R1
endmodule : host_timers

/* dv/host_timers_checker.sv */
// port assertions for the host timer bank
`timescale 1ns/10ps
module host_timers_checker (
	// clock, reset and bus
	input wire logic CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic [7:0] PADDR_IN,
	input wire logic PREADY_OUT,
	input wire logic PSLVERR_OUT,
	// data paths
	input wire logic TX_WORD_VALID_IN,
	input wire logic [31:0] TX_WORD_IN,
	input wire logic TX_WORD_READY_OUT,
	input wire logic TX_HALF_VALID_OUT,
	input wire logic [15:0] TX_HALF_OUT,
	input wire logic RX_HALF_VALID_IN,
	input wire logic [15:0] RX_HALF_IN,
	input wire logic RX_WORD_VALID_OUT,
	input wire logic [31:0] RX_WORD_OUT
);
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!ARST_N_IN);
	logic ph_reg;
	logic [15:0] first_reg;
	logic acc, hit, tk;
	assign acc = PSEL_IN && PENABLE_IN;
	assign hit = PADDR_IN[7:2] inside {6'h23, 6'h24, 6'h26, 6'h27, 6'h2c, 6'h2d, 6'h2e};
	assign tk = TX_WORD_VALID_IN && TX_WORD_READY_OUT;
	// tracks which halfword of a receive pair is arriving
	always_ff @(posedge CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			ph_reg <= 1'b0;
			first_reg <= 16'h0000;
		end else if (RX_HALF_VALID_IN) begin
			ph_reg <= !ph_reg;
			first_reg <= RX_HALF_IN;
		end
	end
	sequence tx_low_s;
		TX_HALF_VALID_OUT && TX_HALF_OUT == $past(TX_WORD_IN[15:0]);
	endsequence
	sequence tx_high_s;
		TX_HALF_VALID_OUT && TX_HALF_OUT == $past(TX_WORD_IN[31:16], 2);
	endsequence
	AST_READY: assert property (acc |-> PREADY_OUT) else $error("ready low");
	AST_UNMAPPED: assert property (acc && !hit |-> PSLVERR_OUT) else $error("no slverr");
	AST_MAPPED: assert property (acc && hit |-> !PSLVERR_OUT) else $error("bad slverr");
	AST_TX_ORDER: assert property (tk |=> tx_low_s ##1 tx_high_s)
		else $error("tx half order");
	AST_TX_HOLD: assert property (tk |=> !TX_WORD_READY_OUT)
		else $error("tx ready early");
	AST_TX_IDLE: assert property (TX_HALF_VALID_OUT |-> $past(tk) || $past(tk, 2))
		else $error("tx stray half");
	AST_RX_WORD: assert property (RX_HALF_VALID_IN && ph_reg |=>
		RX_WORD_VALID_OUT && RX_WORD_OUT == {$past(RX_HALF_IN), $past(first_reg)})
		else $error("rx word");
	AST_RX_QUIET: assert property (!(RX_HALF_VALID_IN && ph_reg) |=> !RX_WORD_VALID_OUT)
		else $error("rx stray word");
endmodule : host_timers_checker

bind host_timers host_timers_checker chk (.CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN,
	.PADDR_IN, .PREADY_OUT, .PSLVERR_OUT, .TX_WORD_VALID_IN, .TX_WORD_IN, .TX_WORD_READY_OUT,
	.TX_HALF_VALID_OUT, .TX_HALF_OUT, .RX_HALF_VALID_IN, .RX_HALF_IN, .RX_WORD_VALID_OUT,
	.RX_WORD_OUT);

/* dv/host_model.sv */
// host processor model issuing register bus transfers
`timescale 1ns/10ps
module host_model (
	// clock
	input wire logic clk_in,
	// bus master side
	output logic psel_out,
	output logic penable_out,
	output logic pwrite_out,
	output logic [7:0] paddr_out,
	output logic [31:0] pwdata_out,
	input wire logic [31:0] prdata_in,
	input wire logic pready_in,
	input wire logic pslverr_in
);
	int cyc = 0;
	int t_setup;
	initial begin
		{psel_out, penable_out, pwrite_out, paddr_out, pwdata_out} = '0;
	end
	always @(posedge clk_in) cyc <= cyc + 1;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err, output logic ok);
		int n;
		@(posedge clk_in);
		psel_out <= 1'b1;
		pwrite_out <= w;
		paddr_out <= a;
		pwdata_out <= d;
		@(posedge clk_in);
		t_setup = cyc;
		penable_out <= 1'b1;
		ok = 1'b0;
		for (n = 0; n < 50 && !ok; n++) begin
			@(posedge clk_in);
			ok = pready_in;
		end
		rd = prdata_in;
		err = pslverr_in;
		psel_out <= 1'b0;
		penable_out <= 1'b0;
		// released lines must not look like held data
		paddr_out <= ~a;
		pwdata_out <= ~d;
	endtask : xfer
endmodule : host_model

/* dv/host_timers_tb.sv */
// bench for the host timer bank with register and stream models
`timescale 1ns/10ps
module host_timers_tb;
	logic CLK_IN = 0, ARST_N_IN = 0, PSEL_IN, PENABLE_IN, PWRITE_IN, PREADY_OUT, PSLVERR_OUT;
	logic TX_WORD_VALID_IN = 0, TX_WORD_READY_OUT, TX_HALF_VALID_OUT, RX_HALF_VALID_IN = 0;
	logic RX_WORD_VALID_OUT, IRQ_OUT, err, ok, ph = 0;
	logic [7:0] PADDR_IN;
	logic [15:0] TX_HALF_OUT, RX_HALF_IN = 0, lo, hq[$];
	logic [31:0] PWDATA_IN, PRDATA_OUT, TX_WORD_IN = 0, RX_WORD_OUT, rd, v, o, q, off, wq[$];
	logic [31:0] seed = 32'h3157;
	int num_errors = 0, comparisons = 0, p, c0, n, i;
	host_timers dut (.CLK_IN, .ARST_N_IN, .PSEL_IN, .PENABLE_IN, .PWRITE_IN, .PADDR_IN,
		.PWDATA_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT, .TX_WORD_VALID_IN, .TX_WORD_IN,
		.TX_WORD_READY_OUT, .TX_HALF_VALID_OUT, .TX_HALF_OUT, .RX_HALF_VALID_IN, .RX_HALF_IN,
		.RX_WORD_VALID_OUT, .RX_WORD_OUT, .IRQ_OUT);
	host_model host (.clk_in(CLK_IN), .psel_out(PSEL_IN), .penable_out(PENABLE_IN),
		.pwrite_out(PWRITE_IN), .paddr_out(PADDR_IN), .pwdata_out(PWDATA_IN),
		.prdata_in(PRDATA_OUT), .pready_in(PREADY_OUT), .pslverr_in(PSLVERR_OUT));
	initial begin
		forever #20 CLK_IN = !CLK_IN;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : compare
	task automatic give_verdict();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : give_verdict
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		host.xfer(w, a, d, rd, err, ok);
		if (!ok) begin
			num_errors++;
			give_verdict();
		end
	endtask : bus
	task automatic wait_irq(input logic lvl);
		for (n = 0; n < 500 && IRQ_OUT !== lvl; n++) @(posedge CLK_IN);
		compare(IRQ_OUT, lvl);
		if (IRQ_OUT !== lvl) give_verdict();
	endtask : wait_irq
	// stream traffic with stalls; the models expect low halfword first
	always @(posedge CLK_IN) begin
		if (ARST_N_IN) begin
			if (TX_HALF_VALID_OUT) compare(TX_HALF_OUT, hq.pop_front());
			if (TX_WORD_VALID_IN && TX_WORD_READY_OUT) begin
				hq.push_back(TX_WORD_IN[15:0]);
				hq.push_back(TX_WORD_IN[31:16]);
			end
			if (!TX_WORD_VALID_IN || TX_WORD_READY_OUT) begin
				TX_WORD_VALID_IN <= rnd() > 32'h80000000;
				TX_WORD_IN <= rnd();
			end
			if (RX_WORD_VALID_OUT) compare(RX_WORD_OUT, wq.pop_front());
			if (RX_HALF_VALID_IN) begin
				if (ph) wq.push_back({RX_HALF_IN, lo});
				lo = RX_HALF_IN;
				ph = !ph;
			end
			RX_HALF_VALID_IN <= rnd() > 32'h80000000;
			RX_HALF_IN <= 16'(rnd());
		end else begin
			// reset drops whatever was in flight on both streams
			hq.delete();
			wq.delete();
			ph = 0;
		end
	end
	initial begin
		repeat (10) @(posedge CLK_IN);
		ARST_N_IN <= 1'b1;
		bus(0, 8'h9c, 0);
		compare(rd, 0);
		bus(0, 8'h8c, 0);
		compare(rd, 32'h0000ffff);
		bus(0, 8'h90, 0);
		compare(rd, 32'h0000ffff);
		bus(0, 8'h98, 0);
		compare(rd, 0);
		bus(1, 8'ha0, 0);
		compare(err, 1);
		p = 20 + rnd() % 40;
		bus(1, 8'h8c, 32'h20000000 | p);
		repeat (p + 5) @(posedge CLK_IN);
		compare(IRQ_OUT, 0);
		bus(1, 8'hb4, 1);
		wait_irq(1);
		bus(0, 8'hb0, 0);
		compare(rd, 1);
		wait_irq(0);
		wait_irq(1);
		c0 = host.cyc;
		bus(0, 8'hb0, 0);
		wait_irq(0);
		wait_irq(1);
		compare(host.cyc - c0, p + 1);
		bus(1, 8'h8c, 0);
		bus(0, 8'h8c, 0);
		compare(rd, 32'h0000ffff);
		bus(0, 8'h90, 0);
		v = rd;
		bus(0, 8'h90, 0);
		compare(rd, v);
		bus(0, 8'hb0, 0);
		bus(0, 8'hb0, 0);
		compare(rd, 0);
		compare(IRQ_OUT, 0);
		q = rnd() & 32'h0000ffff;
		bus(1, 8'h8c, q);
		bus(0, 8'h9c, 0);
		off = rd - host.t_setup;
		bus(0, 8'h9c, 0);
		compare(rd, off + host.t_setup);
		for (i = 0; i < 3; i++) begin
			o = i == 0 ? 0 : i == 1 ? rnd() & 32'hfffffffe : 32'hffffffff;
			bus(1, 8'h98, o);
			bus(1, 8'hb8, 1);
			bus(0, 8'h8c, 0);
			compare(rd[15:0], i == 2 ? 0 : q);
			bus(0, 8'h8e, 0);
			compare(rd[15:0], i == 2 ? q : 0);
			bus(0, i == 2 ? 8'h9c : 8'h9e, 0);
			v = off + host.t_setup;
			compare(rd[15:0], v[31:16]);
			bus(0, i == 2 ? 8'h9e : 8'h9c, 0);
			compare(rd[15:0], v[15:0]);
			bus(1, i == 2 ? 8'hba : 8'hb8, 0);
			bus(0, 8'h8c, 0);
			compare(rd, q);
		end
		// second reset in mid-run: counter clears, preload back to ones
		ARST_N_IN <= 1'b0;
		@(posedge CLK_IN);
		ARST_N_IN <= 1'b1;
		bus(0, 8'h9c, 0);
		compare(rd, 0);
		bus(0, 8'h8c, 0);
		compare(rd, 32'h0000ffff);
		give_verdict();
	end
endmodule : host_timers_tb
